// ---- inc/xfer_exec_pkg.sv ----
// Purpose: Shared constants and types of the transfer and bit execution unit.
// Assumes: Word-aligned AHB-Lite register map, 8-bit data path.
// Notes:   Offsets are byte addresses on the register bus.
package xfer_exec_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CMD    = 8'h00;
  localparam logic [7:0] A_OPND   = 8'h04;
  localparam logic [7:0] A_FLAGS  = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0C;
  localparam logic [7:0] A_SP     = 8'h10;
  localparam logic [7:0] A_RIDX   = 8'h14;
  localparam logic [7:0] A_RDATA  = 8'h18;
  // ---------------------------------------------------------------
  // Command word fields
  // ---------------------------------------------------------------
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_REG_LSB = 5;
  localparam int CMD_BIT_LSB = 10;
  localparam int CMD_PTR_LSB = 13;
  localparam int CMD_MOD_LSB = 15;
  localparam int CMD_R0_BIT  = 17;
  // Pointer modes.
  localparam logic [1:0] MODE_PLAIN = 2'h0;
  localparam logic [1:0] MODE_INC   = 2'h1;
  localparam logic [1:0] MODE_DEC   = 2'h2;
  // Flag bit positions.
  localparam int F_C = 0;
  localparam int F_Z = 1;
  localparam int F_N = 2;
  localparam int F_V = 3;
  localparam int F_T = 6;
  // Pointer pairs start at this register; second pair follows.
  localparam int PTR_BASE = 26;
  // Reset values.
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] SP_RST    = 16'h00FF;
  typedef enum logic [4:0] {
    op_none, op_load_indirect, op_load_with_offset, op_load_direct,
    op_store_indirect, op_store_with_offset, op_store_direct,
    op_program_memory_load, op_push, op_pop, op_io_bit_set,
    op_io_bit_clear, op_logical_left_shift, op_logical_right_shift,
    op_rotate_left_carry, op_rotate_right_carry, op_arith_right_shift,
    op_bit_to_transfer, op_transfer_to_bit, op_flag_set, op_flag_clear,
    op_port_in, op_port_out, op_nibble_swap
  } op_t;
endpackage

// ---- logic/xfer_exec.sv ----
// Purpose: Executes transfer, shift, bit and flag operations on request.
// Assumes: Data memory answers one cycle after dmem_re; program memory
//          data is valid one cycle after pmem_re and held; I/O reads
//          are combinational.
// Notes:   Commands arrive over AHB-Lite; one operation at a time.
// How it works
// - Offset load reads pointer plus unsigned offset, 2 cycles, pointer kept.
// - Direct load copies data byte at given address, 2 cycles, flags kept.
// - Direct store writes source register to given address, 2 cycles.
// - Post-increment store writes at pointer then adds one, 2 cycles.
// - Pre-decrement store subtracts one first then writes, 2 cycles.
// - Offset store writes at pointer plus offset, pointer kept, 2 cycles.
// - Program load reads at third pointer, into register zero when CMD_R0_BIT is set, 3 cycles.
// - Push places source register on the stack in 2 cycles.
// - Pop moves top stack byte into destination in 2 cycles.
// - I/O bit set forces one bit high, others kept, 2 cycles.
// - I/O bit clear forces one bit low, others kept, 2 cycles.
// - Left shift inserts zero at bit 0, sets Z C N V, 1 cycle.
// - Right shift inserts zero at bit 7, sets Z C N V, 1 cycle.
// - Left rotate through carry, updates Z C N V, 1 cycle.
// - Right rotate through carry, updates Z C N V, 1 cycle.
// - Arithmetic right shift keeps sign, updates Z C N V, 1 cycle.
// - Bit-to-transfer copies a register bit into T only, 1 cycle.
// - Transfer-to-bit copies T into a register bit, 1 cycle.
// - Flag set and clear change only their own flag, 1 cycle.
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module xfer_exec
  import xfer_exec_pkg::*;
#(
  parameter int AW  = 16,
  parameter int QW  = 6,
  parameter int IOW = 6
)(
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic [31:0]        hrdata,
  output logic               hresp,
  output logic [AW-1:0]      dmem_addr,
  output logic [7:0]         dmem_wdata,
  output logic               dmem_we,
  output logic               dmem_re,
  input  wire logic [7:0]    dmem_rdata,
  output logic [AW-1:0]      pmem_addr,
  output logic               pmem_re,
  input  wire logic [7:0]    pmem_rdata,
  output logic [IOW-1:0]     io_addr,
  output logic [7:0]         io_wdata,
  output logic               io_we,
  output logic               io_re,
  input  wire logic [7:0]    io_rdata,
  output logic [7:0]         flag_register
);
  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  // Number of busy cycles of each operation.
  function automatic logic [1:0] cycles_of(op_t o);
    case (o)
      op_program_memory_load: cycles_of = 2'd3;
      op_load_indirect, op_load_with_offset, op_load_direct,
      op_store_indirect, op_store_with_offset, op_store_direct,
      op_push, op_pop, op_io_bit_set, op_io_bit_clear:
        cycles_of = 2'd2;
      default: cycles_of = 2'd1;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic [7:0]    gpr [32];
  logic          a_wr;
  logic [7:0]    a_addr;
  logic [17:0]   cmd;
  logic [15:0]   opnd;
  logic [4:0]    ridx;
  logic [15:0]   sp;
  logic [1:0]    remain;
  logic [3:0]    last_cycles;
  logic          busy;
  logic          wr_cmd;
  logic          launch;
  logic          complete;
  logic          bus_ok;
  logic [31:0]   rd_mux;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign busy      = (remain != 2'd0);
  assign complete  = (remain == 2'd1);
  assign bus_ok    = a_wr && !busy;
  assign wr_cmd    = bus_ok && (a_addr == A_CMD);
  assign launch    = wr_cmd;

  // Address phase is captured; only whole-word transfers are expected.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      a_wr   <= 1'b0;
      a_addr <= 8'h00;
    end
    else
    begin
      a_wr   <= hready && hsel && htrans[1] && hwrite;
      a_addr <= haddr[7:0];
    end
  end

  // Read data is prepared in the address phase so reads need no wait.
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      A_CMD:    rd_mux = {14'h0000, cmd};
      A_OPND:   rd_mux = {16'h0000, opnd};
      A_FLAGS:  rd_mux = {24'h000000, flag_register};
      A_STATUS: rd_mux = {20'h00000, last_cycles, 7'h00, busy};
      A_SP:     rd_mux = {16'h0000, sp};
      A_RIDX:   rd_mux = {27'h0000000, ridx};
      A_RDATA:  rd_mux = {24'h000000, gpr[ridx]};
      default:  rd_mux = 32'h0000_0000;
    endcase
  end

  // Unmapped reads return zero.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
      hrdata <= rd_mux;
  end

  // Writes are dropped while an operation runs, so state cannot tear.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmd  <= 18'h00000;
      opnd <= 16'h0000;
      ridx <= 5'h00;
    end
    else if (bus_ok)
    begin
      if (a_addr == A_CMD)
        cmd <= hwdata[17:0];
      if (a_addr == A_OPND)
        opnd <= hwdata[15:0];
      if (a_addr == A_RIDX)
        ridx <= hwdata[4:0];
    end
  end

  // ---------------------------------------------------------------
  // Command decode at launch
  // ---------------------------------------------------------------
  op_t           n_op;
  logic [4:0]    n_reg;
  logic [1:0]    n_psel;
  logic [1:0]    n_mode;
  logic [4:0]    pbase_n;
  logic [15:0]   ptr_n;
  logic [15:0]   ea;
  logic [15:0]   ptr_upd_n;

  assign n_op   = op_t'(hwdata[CMD_OP_LSB +: 5]);
  assign n_reg  = hwdata[CMD_REG_LSB +: 5];
  assign n_psel = hwdata[CMD_PTR_LSB +: 2];
  assign n_mode = hwdata[CMD_MOD_LSB +: 2];

  // Pointer pair select; offset and program loads never use the first.
  always_comb
  begin
    pbase_n = 5'(PTR_BASE + 4);
    case (n_op)
      op_load_with_offset, op_store_with_offset:
        pbase_n = (n_psel == 2'd1) ? 5'(PTR_BASE + 2) : 5'(PTR_BASE + 4);
      op_program_memory_load:
        pbase_n = 5'(PTR_BASE + 4);
      default:
        pbase_n = 5'(PTR_BASE + 2 * int'(n_psel));
    endcase
  end

  assign ptr_n = {gpr[pbase_n + 5'd1], gpr[pbase_n]};

  // Effective address and the pointer value left after the access.
  always_comb
  begin
    ea        = ptr_n;
    ptr_upd_n = ptr_n;
    case (n_op)
      op_load_with_offset, op_store_with_offset:
        ea = ptr_n + {{(16-QW){1'b0}}, opnd[QW-1:0]};
      op_load_direct, op_store_direct:
        ea = opnd;
      op_load_indirect, op_store_indirect, op_program_memory_load:
      begin
        if (n_mode == MODE_DEC)
        begin
          ea        = ptr_n - 16'd1;
          ptr_upd_n = ptr_n - 16'd1;
        end
        else if (n_mode == MODE_INC)
          ptr_upd_n = ptr_n + 16'd1;
      end
      op_push:
        ea = sp;
      op_pop:
        ea = sp + 16'd1;
      default:
        ea = ptr_n;
    endcase
  end

  // ---------------------------------------------------------------
  // Latched operation and cycle counter
  // ---------------------------------------------------------------
  op_t           op;
  logic [4:0]    dreg;
  logic [2:0]    bsel;
  logic [4:0]    pbase;
  logic [15:0]   ptr_upd;
  logic          ptr_wr;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      op      <= op_none;
      dreg    <= 5'h00;
      bsel    <= 3'h0;
      pbase   <= 5'h00;
      ptr_upd <= 16'h0000;
      ptr_wr  <= 1'b0;
    end
    else if (launch)
    begin
      op    <= n_op;
      dreg  <= (n_op == op_program_memory_load && hwdata[CMD_R0_BIT])
               ? 5'd0 : n_reg;
      bsel    <= hwdata[CMD_BIT_LSB +: 3];
      pbase   <= pbase_n;
      ptr_upd <= ptr_upd_n;
      // Offset loads and stores leave the pointer alone.
      ptr_wr  <= (n_op == op_load_indirect || n_op == op_store_indirect
                  || n_op == op_program_memory_load)
                 && (n_mode == MODE_INC || n_mode == MODE_DEC);
    end
  end

  // Busy cycles follow the documented count of each operation.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      remain      <= 2'd0;
      last_cycles <= 4'h0;
    end
    else if (launch)
    begin
      remain      <= cycles_of(n_op);
      last_cycles <= {2'b00, cycles_of(n_op)};
    end
    else if (busy)
      remain <= remain - 2'd1;
  end

  // ---------------------------------------------------------------
  // Memory and I/O strobes
  // ---------------------------------------------------------------
  // Requests go out in the first busy cycle; the I/O bit write follows
  // in the second, after the old value has been read.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dmem_addr  <= '0;
      dmem_wdata <= 8'h00;
      dmem_we    <= 1'b0;
      dmem_re    <= 1'b0;
      pmem_addr  <= '0;
      pmem_re    <= 1'b0;
      io_addr    <= '0;
      io_wdata   <= 8'h00;
      io_we      <= 1'b0;
      io_re      <= 1'b0;
    end
    else if (launch)
    begin
      dmem_addr  <= AW'(ea);
      dmem_wdata <= gpr[n_reg];
      dmem_we    <= (n_op == op_store_indirect || n_op == op_store_with_offset
                     || n_op == op_store_direct || n_op == op_push);
      dmem_re    <= (n_op == op_load_indirect || n_op == op_load_with_offset
                     || n_op == op_load_direct || n_op == op_pop);
      pmem_addr  <= AW'(ea);
      pmem_re    <= (n_op == op_program_memory_load);
      io_addr    <= opnd[IOW-1:0];
      io_wdata   <= gpr[n_reg];
      io_we      <= (n_op == op_port_out);
      io_re      <= (n_op == op_port_in || n_op == op_io_bit_set
                     || n_op == op_io_bit_clear);
    end
    else
    begin
      dmem_we <= 1'b0;
      dmem_re <= 1'b0;
      pmem_re <= 1'b0;
      io_re   <= 1'b0;
      io_we   <= 1'b0;
      if (remain == 2'd2 && op == op_io_bit_set)
      begin
        io_wdata <= io_rdata | (8'h01 << bsel);
        io_we    <= 1'b1;
      end
      if (remain == 2'd2 && op == op_io_bit_clear)
      begin
        io_wdata <= io_rdata & ~(8'h01 << bsel);
        io_we    <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Result and flag computation in the final cycle
  // ---------------------------------------------------------------
  logic [7:0]    rd;
  logic [7:0]    res;
  logic          res_wr;
  logic          c_new;
  logic          shift_op;
  logic [7:0]    next_flags;

  assign rd = gpr[dreg];

  always_comb
  begin
    res      = rd;
    res_wr   = 1'b0;
    c_new    = flag_register[F_C];
    shift_op = 1'b0;
    case (op)
      op_load_indirect, op_load_with_offset, op_load_direct, op_pop:
      begin
        res    = dmem_rdata;
        res_wr = 1'b1;
      end
      op_program_memory_load:
      begin
        res    = pmem_rdata;
        res_wr = 1'b1;
      end
      op_port_in:
      begin
        res    = io_rdata;
        res_wr = 1'b1;
      end
      op_nibble_swap:
      begin
        res    = {rd[3:0], rd[7:4]};
        res_wr = 1'b1;
      end
      op_logical_left_shift:
      begin
        res      = {rd[6:0], 1'b0};
        c_new    = rd[7];
        res_wr   = 1'b1;
        shift_op = 1'b1;
      end
      op_logical_right_shift:
      begin
        res      = {1'b0, rd[7:1]};
        c_new    = rd[0];
        res_wr   = 1'b1;
        shift_op = 1'b1;
      end
      op_rotate_left_carry:
      begin
        res      = {rd[6:0], flag_register[F_C]};
        c_new    = rd[7];
        res_wr   = 1'b1;
        shift_op = 1'b1;
      end
      op_rotate_right_carry:
      begin
        res      = {flag_register[F_C], rd[7:1]};
        c_new    = rd[0];
        res_wr   = 1'b1;
        shift_op = 1'b1;
      end
      op_arith_right_shift:
      begin
        res      = {rd[7], rd[7:1]};
        c_new    = rd[0];
        res_wr   = 1'b1;
        shift_op = 1'b1;
      end
      op_transfer_to_bit:
      begin
        res       = rd;
        res[bsel] = flag_register[F_T];
        res_wr    = 1'b1;
      end
      default:
      begin
        res    = rd;
        res_wr = 1'b0;
      end
    endcase
  end

  // Only shifts, bit-to-transfer and flag set or clear touch flags.
  always_comb
  begin
    next_flags = flag_register;
    if (shift_op)
    begin
      next_flags[F_C] = c_new;
      next_flags[F_N] = res[7];
      next_flags[F_Z] = (res == 8'h00);
      next_flags[F_V] = res[7] ^ c_new;
    end
    else if (op == op_bit_to_transfer)
      next_flags[F_T] = rd[bsel];
    else if (op == op_flag_set)
      next_flags[bsel] = 1'b1;
    else if (op == op_flag_clear)
      next_flags[bsel] = 1'b0;
  end

  // Software may also load the flags while idle.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flag_register <= FLAGS_RST;
    else if (complete)
      flag_register <= next_flags;
    else if (bus_ok && a_addr == A_FLAGS)
      flag_register <= hwdata[7:0];
  end

  // Stack pointer moves down on push and up on pop.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sp <= SP_RST;
    else if (complete && op == op_push)
      sp <= sp - 16'd1;
    else if (complete && op == op_pop)
      sp <= sp + 16'd1;
    else if (bus_ok && a_addr == A_SP)
      sp <= hwdata[15:0];
  end

  // ---------------------------------------------------------------
  // General register file
  // ---------------------------------------------------------------
  // The destination byte wins over a pointer update of the same register,
  // a case that well-formed programs avoid.
  for (genvar i = 0; i < 32; i++)
  begin : g_gpr
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        gpr[i] <= 8'h00;
      else if (complete && res_wr && dreg == 5'(i))
        gpr[i] <= res;
      else if (complete && ptr_wr && pbase == 5'(i))
        gpr[i] <= ptr_upd[7:0];
      else if (complete && ptr_wr && pbase + 5'd1 == 5'(i))
        gpr[i] <= ptr_upd[15:8];
      else if (bus_ok && a_addr == A_RDATA && ridx == 5'(i))
        gpr[i] <= hwdata[7:0];
    end
  end

endmodule

// ---- test/mem_model.sv ----
// Purpose: Data, program and I/O memories beside the unit.
// Assumes: Low address byte decoded only.
// Notes:   Fixed start patterns.
`timescale 1ns/1ps
module mem_model #(
  parameter int AW  = 16,
  parameter int IOW = 6
)(
  input wire logic           hclk,
  input wire logic [AW-1:0]  dmem_addr,
  input wire logic [7:0]     dmem_wdata,
  input wire logic           dmem_we,
  input wire logic           dmem_re,
  output logic [7:0]         dmem_rdata,
  input wire logic [AW-1:0]  pmem_addr,
  input wire logic           pmem_re,
  output logic [7:0]         pmem_rdata,
  input wire logic [IOW-1:0] io_addr,
  input wire logic [7:0]     io_wdata,
  input wire logic           io_we,
  input wire logic           io_re,
  output logic [7:0]         io_rdata
);
  logic [7:0] dm [256];
  logic [7:0] pm [256];
  logic [7:0] io [64];
  logic       pm_hold;
  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      dm[i] = 8'(i) ^ 8'hA5;
      pm[i] = ~8'(i);
      if (i < 64) io[i] = 8'(i * 3);
    end
    dmem_rdata = 8'h00;
    pmem_rdata = 8'h00;
    pm_hold = 1'b0;
  end
  // Read ports toggle outside their answer cycle.
  always @(posedge hclk)
  begin
    if (dmem_we) dm[dmem_addr[7:0]] <= dmem_wdata;
    if (io_we) io[io_addr] <= io_wdata;
    dmem_rdata <= dmem_re ? dm[dmem_addr[7:0]] : ~dmem_rdata;
    pm_hold <= pmem_re;
    if (pmem_re) pmem_rdata <= pm[pmem_addr[7:0]];
    else if (!pm_hold) pmem_rdata <= ~pmem_rdata;
  end
  assign io_rdata = io_re ? io[io_addr] : ~io[io_addr];
endmodule

// ---- test/testbench.sv ----
// Purpose: Drives commands over the bus and judges results.
// Assumes: Memory contents follow the model patterns.
// Notes:   Cycle counts come from STATUS.
`timescale 1ns/1ps
module testbench;
  import xfer_exec_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dmem_we, dmem_re;
  logic pmem_re, io_we, io_re;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] dmem_addr, pmem_addr, pv;
  logic [7:0] dmem_wdata, dmem_rdata, pmem_rdata, io_wdata, io_rdata, flag_register;
  logic [5:0] io_addr;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  xfer_exec uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .dmem_addr,
    .dmem_wdata, .dmem_we, .dmem_re, .dmem_rdata, .pmem_addr, .pmem_re,
    .pmem_rdata, .io_addr, .io_wdata, .io_we, .io_re, .io_rdata, .flag_register);
  mem_model mdl (.hclk, .dmem_addr, .dmem_wdata, .dmem_we, .dmem_re, .dmem_rdata,
    .pmem_addr, .pmem_re, .pmem_rdata, .io_addr, .io_wdata, .io_we, .io_re, .io_rdata);
  // ---------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ---------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // A hung handshake ends the run.
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end
  task finish_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task setr(input int i, input logic [7:0] v);
    bus(1'b1, A_RIDX, i);
    bus(1'b1, A_RDATA, {24'h0, v});
  endtask
  task getr(input int i);
    bus(1'b1, A_RIDX, i);
    bus(1'b0, A_RDATA, 32'h0);
  endtask
  task setp(input int p, input logic [15:0] v);
    setr(26 + 2 * p, v[7:0]);
    setr(27 + 2 * p, v[15:8]);
  endtask
  task getp(input int p);
    getr(26 + 2 * p);
    pv[7:0] = rv[7:0];
    getr(27 + 2 * p);
    pv[15:8] = rv[7:0];
  endtask
  function logic [31:0] cm(int op, int r, int b, int p, int m, int z);
    return op | r << CMD_REG_LSB | b << CMD_BIT_LSB | p << CMD_PTR_LSB
      | m << CMD_MOD_LSB | z << CMD_R0_BIT;
  endfunction
  // Launches a command, polls until idle, checks its length.
  task run(input logic [31:0] c, input logic [15:0] o, input int n);
    int k;
    bus(1'b1, A_OPND, {16'h0, o});
    bus(1'b1, A_CMD, c);
    k = 0;
    do
    begin
      bus(1'b0, A_STATUS, 32'h0);
      k++;
    end
    while (rv[0] !== 1'b0 && k < 20);
    check("cycles", rv[11:8], n);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_reset;
    bus(1'b0, A_FLAGS, 32'h0);
    check("flags_rst", rv, FLAGS_RST);
    bus(1'b0, A_SP, 32'h0);
    check("sp_rst", rv, SP_RST);
    bus(1'b0, 8'h40, 32'h0);
    check("unmapped", rv, 32'h0);
  endtask
  task t_loads;
    bus(1'b1, A_FLAGS, 32'h3C);
    run(cm(op_load_direct, 5, 0, 0, 0, 0), 16'h0023, 2);
    getr(5);
    check("ld_direct", rv, 8'h23 ^ 8'hA5);
    setp(2, 16'h0040);
    run(cm(op_load_with_offset, 6, 0, 2, 0, 0), 16'h0005, 2);
    getr(6);
    check("ld_offset", rv, 8'h45 ^ 8'hA5);
    getp(2);
    check("z_kept", pv, 16'h0040);
    bus(1'b0, A_FLAGS, 32'h0);
    check("ld_flags", rv, 32'h3C);
  endtask
  task t_stores;
    setr(9, 8'h9C);
    setp(0, 16'h0030);
    setp(1, 16'h0060);
    run(cm(op_store_direct, 9, 0, 0, 0, 0), 16'h0011, 2);
    check("st_direct", mdl.dm[8'h11], 8'h9C);
    run(cm(op_store_indirect, 9, 0, 0, MODE_INC, 0), 16'h0, 2);
    check("st_inc", mdl.dm[8'h30], 8'h9C);
    getp(0);
    check("x_inc", pv, 16'h0031);
    run(cm(op_store_indirect, 9, 0, 1, MODE_DEC, 0), 16'h0, 2);
    check("st_dec", mdl.dm[8'h5F], 8'h9C);
    getp(1);
    check("y_dec", pv, 16'h005F);
    run(cm(op_store_with_offset, 9, 0, 1, 0, 0), 16'h0003, 2);
    check("st_offset", mdl.dm[8'h62], 8'h9C);
    getp(1);
    check("y_kept", pv, 16'h005F);
    bus(1'b0, A_FLAGS, 32'h0);
    check("st_flags", rv, 32'h3C);
  endtask
  task t_prog;
    setp(2, 16'h0010);
    run(cm(op_program_memory_load, 0, 0, 2, MODE_INC, 1), 16'h0, 3);
    getr(0);
    check("pm_zero", rv, 8'hEF);
    getp(2);
    check("z_inc", pv, 16'h0011);
    run(cm(op_program_memory_load, 4, 0, 2, MODE_PLAIN, 0), 16'h0, 3);
    getr(4);
    check("pm_dest", rv, 8'hEE);
  endtask
  task t_stack;
    setr(7, 8'h77);
    run(cm(op_push, 7, 0, 0, 0, 0), 16'h0, 2);
    check("push", mdl.dm[8'hFF], 8'h77);
    bus(1'b0, A_SP, 32'h0);
    check("sp_dec", rv, 32'h00FE);
    run(cm(op_pop, 8, 0, 0, 0, 0), 16'h0, 2);
    getr(8);
    check("pop", rv, 8'h77);
    bus(1'b0, A_SP, 32'h0);
    check("sp_inc", rv, 32'h00FF);
  endtask
  task t_io;
    run(cm(op_io_bit_set, 0, 1, 0, 0, 0), 16'h0003, 2);
    check("bit_set", mdl.io[3], 8'h0B);
    run(cm(op_io_bit_clear, 0, 3, 0, 0, 0), 16'h0003, 2);
    check("bit_clr", mdl.io[3], 8'h03);
    setr(9, 8'hA7);
    run(cm(op_port_out, 9, 0, 0, 0, 0), 16'h0007, 1);
    check("port_out", mdl.io[7], 8'hA7);
    run(cm(op_port_in, 10, 0, 0, 0, 0), 16'h0007, 1);
    run(cm(op_nibble_swap, 10, 0, 0, 0, 0), 16'h0, 1);
    getr(10);
    check("in_swap", rv, 8'h7A);
  endtask
  // Carry enters as one; S and H must stay set.
  task t_shift;
    logic [7:0] v, r;
    logic       c;
    int         op;
    for (int i = 0; i < 10; i++)
    begin
      op = 12 + i / 2;
      v = i[0] ? 8'h80 : 8'h96;
      bus(1'b1, A_FLAGS, 32'h31);
      setr(3, v);
      case (op)
        12: {c, r} = {v, 1'b0};
        13: {r, c} = {1'b0, v};
        14: {c, r} = {v, 1'b1};
        15: {r, c} = {1'b1, v};
        default: {r, c} = {v[7], v};
      endcase
      run(cm(op, 3, 0, 0, 0, 0), 16'h0, 1);
      getr(3);
      check("shift", rv, r);
      bus(1'b0, A_FLAGS, 32'h0);
      check("sh_flags", rv, {4'h3, r[7] ^ c, r[7], r == 8'h0, c});
    end
  endtask
  task t_bits;
    setr(11, 8'h08);
    bus(1'b1, A_FLAGS, 32'h0);
    run(cm(op_bit_to_transfer, 11, 3, 0, 0, 0), 16'h0, 1);
    bus(1'b0, A_FLAGS, 32'h0);
    check("t_store", rv, 32'h40);
    setr(12, 8'h81);
    run(cm(op_transfer_to_bit, 12, 5, 0, 0, 0), 16'h0, 1);
    getr(12);
    check("t_load", rv, 8'hA1);
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, A_FLAGS, 32'h0);
      run(cm(op_flag_set, 0, i, 0, 0, 0), 16'h0, 1);
      bus(1'b0, A_FLAGS, 32'h0);
      check("flag_set", rv, 32'h1 << i);
      bus(1'b1, A_FLAGS, 32'hFF);
      run(cm(op_flag_clear, 0, i, 0, 0, 0), 16'h0, 1);
      bus(1'b0, A_FLAGS, 32'h0);
      check("flag_clr", rv, 32'hFF ^ (32'h1 << i));
    end
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_loads;
    t_stores;
    t_prog;
    t_stack;
    t_io;
    t_shift;
    t_bits;
    finish_test;
  end
endmodule
bind xfer_exec xfer_exec_assertions #(.AW(AW), .IOW(IOW)) chk (.hclk, .hresetn,
  .hreadyout, .hresp, .dmem_addr, .dmem_wdata, .dmem_we, .dmem_re, .pmem_addr,
  .pmem_re, .io_we, .io_re, .flag_register);

// ---- test/xfer_exec_assertions.sv ----
// Purpose: Port checks of the unit's strobes and flags.
// Assumes: One operation at a time.
// Notes:   Bound from the testbench.
`timescale 1ns/1ps
module xfer_exec_assertions
  import xfer_exec_pkg::*;
#(
  parameter int AW  = 16,
  parameter int IOW = 6
)(
  input wire logic          hclk,
  input wire logic          hresetn,
  input wire logic          hreadyout,
  input wire logic          hresp,
  input wire logic [AW-1:0] dmem_addr,
  input wire logic [7:0]    dmem_wdata,
  input wire logic          dmem_we,
  input wire logic          dmem_re,
  input wire logic [AW-1:0] pmem_addr,
  input wire logic          pmem_re,
  input wire logic          io_we,
  input wire logic          io_re,
  input wire logic [7:0]    flag_register
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A memory strobe opens an operation.
  sequence s_mem_strobe;
    dmem_we || dmem_re;
  endsequence
  // Program data is sampled late, so the address must hold.
  sequence s_pm_wait;
    (!pmem_re && $stable(pmem_addr)) [*2];
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not okay");
  chk_dm_write: assert property (
    dmem_we |=> !dmem_we && $stable(dmem_addr) && $stable(dmem_wdata))
    else $error("bad write pulse");
  chk_dm_read: assert property (
    dmem_re |=> !dmem_re && !dmem_we && $stable(dmem_addr))
    else $error("bad read pulse");
  chk_mem_flags: assert property (
    s_mem_strobe |=> $stable(flag_register) [*2])
    else $error("flags moved in memory op");
  chk_pm_hold: assert property (pmem_re |=> s_pm_wait)
    else $error("program load too short");
  chk_pm_alone: assert property (
    pmem_re |-> !(dmem_re || dmem_we || io_re || io_we))
    else $error("strobe beside program load");
  chk_io_flags: assert property (io_re |=> $stable(flag_register))
    else $error("flags moved in I/O op");
  chk_io_rmw: assert property (io_we |-> !io_re && !$past(io_we))
    else $error("bad I/O write pulse");
endmodule
